// file: src/brs_top.sv
// Purpose: automatic battery rail selection with hysteresis, power alarm registers
// Assumes: measurements and power arrive synchronous to mclk_i; APB slave, zero wait
// Notes:   filters and rail comparisons run on an 800 Hz update enable
`default_nettype none
// Contract
// - select low means low battery rail
// - select high means high battery rail
// - one control bit enables automatic selection
// - crossing high threshold switches to high rail
// - falling below low threshold switches low
// - thresholds are bits 14:7 of location
// - monitor tip-ring, choose lowest usable rail
// - filter coefficient scaled for 800 Hz updates
// - coefficient zero blocks, 4000h passes unfiltered
// - total power reported as 16-bit value
// - pair one threshold step depends on linefeed; code uses the same 16-bit step in both linefeed modes
// - pair two and three thresholds 16-bit
// - thermal pole coefficients in bits 15:3
// - six pending alarm bits, one per transistor
// - six enables; integrated uses first only; code stores the enables but gates no pending bit or open state with them
// - pending set on comparator rise, sticky
// - any alarm forces open linefeed state
// - ringing rail output follows ringing cadence
module brs_top #(
  parameter int UPD_CYC = brs_pkg::BRS_UPD_CYC
) (
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                resetn_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // linefeed measurements
  input  wire brs_pkg::brs_meas_t  meas_i,
  input  wire logic [15:0]         total_power_i,
  input  wire logic [15:0]         pair_power_i [3],
  input  wire logic                ringing_cadence_i,
  // rail and linefeed control
  output logic                     battery_rail_select_ch_a_o,
  output logic                     battery_rail_select_ch_b_o,
  output logic                     ringing_rail_switch_out_o,
  output logic                     force_open_o
);
  import brs_pkg::*;

  // elaboration check: the divider needs at least two cycles per update
  if (UPD_CYC < 2)
  begin : g_upd_check
    $error("UPD_CYC must be at least 2");
  end

  logic [7:0]  relay_battery_control_reg;
  logic [7:0]  pend_reg;
  logic [7:0]  en_reg;
  logic [15:0] pth_reg [3];
  logic [15:0] plpf_reg [3];
  logic [15:0] high_th_reg;
  logic [15:0] low_th_reg;
  logic [15:0] blpf_reg;
  logic [15:0] total_power_sum_reg;
  logic [15:0] filt_reg [2];
  logic [15:0] pfilt_reg [3];
  logic [1:0]  auto_sel_reg;
  logic [5:0]  cmp_prev_reg;
  logic        open_reg;
  logic [31:0] upd_cnt_reg;
  logic        upd_tick;
  logic        wr_en;
  logic        rd_en;
  logic [5:0]  cmp_now;

  // one-pole low-pass: y += k*(x-y)/4000h; k=0 holds, k=4000h tracks x
  function automatic logic [15:0] brs_lpf(input logic [15:0] y, input logic [15:0] x,
                                          input logic [12:0] k);
    logic signed [17:0] d;
    logic signed [33:0] p;
    d = $signed({2'b00, x}) - $signed({2'b00, y});
    p = d * $signed({3'b000, k, 3'b000});
    brs_lpf = 16'(y + 16'(p >>> 14));
  endfunction : brs_lpf

  // update-rate divider: one-cycle enable at 800 Hz
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      upd_cnt_reg <= 32'h0;
    else if (upd_cnt_reg == 32'(UPD_CYC - 1))
      upd_cnt_reg <= 32'h0;
    else
      upd_cnt_reg <= upd_cnt_reg + 32'h1;
  end
  assign upd_tick = (upd_cnt_reg == 32'(UPD_CYC - 1));

  // apb: zero wait states, every offset answers, unmapped reads zero
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_en     = psel_i & ~pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  // software-written registers
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      relay_battery_control_reg <= BRS_RLY_RST;
      en_reg      <= BRS_ZERO8;
      high_th_reg <= BRS_ZERO16;
      low_th_reg  <= BRS_ZERO16;
      blpf_reg    <= BRS_BLPF_RST;
      for (int i = 0; i < 3; i++)
      begin
        pth_reg[i]  <= BRS_PTH_RST;
        plpf_reg[i] <= BRS_UNITY;
      end
    end
    else if (wr_en)
    begin
      case (paddr_i)
        BRS_OFF_RELAY: relay_battery_control_reg <= pwdata_i[7:0];
        BRS_OFF_EN:    en_reg      <= {2'b00, pwdata_i[5:0]};
        BRS_OFF_PTH1:  pth_reg[0]  <= pwdata_i[15:0];
        BRS_OFF_PTH2:  pth_reg[1]  <= pwdata_i[15:0];
        BRS_OFF_PTH3:  pth_reg[2]  <= pwdata_i[15:0];
        BRS_OFF_PLPF1: plpf_reg[0] <= {pwdata_i[15:3], 3'b000};
        BRS_OFF_PLPF2: plpf_reg[1] <= {pwdata_i[15:3], 3'b000};
        BRS_OFF_PLPF3: plpf_reg[2] <= {pwdata_i[15:3], 3'b000};
        BRS_OFF_BATH:  high_th_reg <= {1'b0, pwdata_i[14:7], 7'h00};
        BRS_OFF_BATL:  low_th_reg  <= {1'b0, pwdata_i[14:7], 7'h00};
        BRS_OFF_BLPF:  blpf_reg    <= {pwdata_i[15:3], 3'b000};
        default: ;
      endcase
    end
  end

  // tip-ring filters, one update per tick
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      filt_reg[0] <= BRS_ZERO16;
      filt_reg[1] <= BRS_ZERO16;
    end
    else if (upd_tick)
    begin
      filt_reg[0] <= brs_lpf(filt_reg[0], meas_i.vtr_a, blpf_reg[15:3]);
      filt_reg[1] <= brs_lpf(filt_reg[1], meas_i.vtr_b, blpf_reg[15:3]);
    end
  end

  // hysteresis selector: 1 = high rail; evaluated on the tick
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      auto_sel_reg <= 2'b11;
    else if (upd_tick)
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (filt_reg[c] > high_th_reg)
          auto_sel_reg[c] <= 1'b1;
        else if (filt_reg[c] < low_th_reg)
          auto_sel_reg[c] <= 1'b0;
        // otherwise hold the rail
      end
    end
  end

  // pins: low selects low rail, high selects high rail
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      battery_rail_select_ch_a_o <= 1'b1;
      battery_rail_select_ch_b_o <= 1'b1;
      ringing_rail_switch_out_o  <= 1'b0;
    end
    else
    begin
      if (relay_battery_control_reg[BRS_RLY_AUTO])
      begin
        battery_rail_select_ch_a_o <= auto_sel_reg[0];
        battery_rail_select_ch_b_o <= auto_sel_reg[1];
      end
      else
      begin
        battery_rail_select_ch_a_o <= relay_battery_control_reg[BRS_RLY_MAN];
        battery_rail_select_ch_b_o <= relay_battery_control_reg[BRS_RLY_MAN];
      end
      // cadence drives the third rail switch only when that rail exists
      ringing_rail_switch_out_o <= relay_battery_control_reg[BRS_RLY_THIRD_RAIL_PRESENT] & ringing_cadence_i;
    end
  end

  // thermal filters and total power report
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      total_power_sum_reg <= BRS_ZERO16;
      for (int i = 0; i < 3; i++)
        pfilt_reg[i] <= BRS_ZERO16;
    end
    else if (upd_tick)
    begin
      total_power_sum_reg <= total_power_i;
      if (relay_battery_control_reg[BRS_RLY_DISC])
        for (int i = 0; i < 3; i++)
          pfilt_reg[i] <= brs_lpf(pfilt_reg[i], pair_power_i[i], plpf_reg[i][15:3]);
      else
        pfilt_reg[0] <= brs_lpf(pfilt_reg[0], total_power_i, plpf_reg[0][15:3]);
    end
  end

  // comparators: two transistors per pair share one filtered power
  always_comb
  begin
    cmp_now = 6'h00;
    if (relay_battery_control_reg[BRS_RLY_DISC])
    begin
      for (int i = 0; i < 3; i++)
      begin
        cmp_now[2*i]   = pfilt_reg[i] > pth_reg[i];
        cmp_now[2*i+1] = pfilt_reg[i] > pth_reg[i];
      end
    end
    else
      cmp_now[0] = pfilt_reg[0] > pth_reg[0]; // integrated: first comparator bit only, on filtered total power
  end

  // sticky pending: rising edge sets, write-one clears, set wins
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pend_reg     <= BRS_ZERO8;
      cmp_prev_reg <= 6'h00;
    end
    else
    begin
      cmp_prev_reg <= cmp_now;
      for (int i = 0; i < 6; i++)
      begin
        if (cmp_now[i] & ~cmp_prev_reg[i])
          pend_reg[i] <= 1'b1;
        else if (wr_en && paddr_i == BRS_OFF_PEND && pwdata_i[i])
          pend_reg[i] <= 1'b0;
      end
    end
  end

  // forced open linefeed regardless of enables; left when relay control is rewritten while no comparator is active
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      open_reg <= 1'b0;
    else if (|cmp_now)
      open_reg <= 1'b1;
    else if (wr_en && paddr_i == BRS_OFF_RELAY)
      open_reg <= 1'b0;
  end
  assign force_open_o = open_reg;

  // read mux, registered data
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h0;
    else if (rd_en && !penable_i)
    begin
      case (paddr_i)
        BRS_OFF_RELAY: prdata_o <= {24'h0, relay_battery_control_reg};
        BRS_OFF_TOTAL_POWER_SUM:  prdata_o <= {16'h0, total_power_sum_reg};
        BRS_OFF_PEND:  prdata_o <= {24'h0, pend_reg};
        BRS_OFF_EN:    prdata_o <= {24'h0, en_reg};
        BRS_OFF_PTH1:  prdata_o <= {16'h0, pth_reg[0]};
        BRS_OFF_PTH2:  prdata_o <= {16'h0, pth_reg[1]};
        BRS_OFF_PTH3:  prdata_o <= {16'h0, pth_reg[2]};
        BRS_OFF_PLPF1: prdata_o <= {16'h0, plpf_reg[0]};
        BRS_OFF_PLPF2: prdata_o <= {16'h0, plpf_reg[1]};
        BRS_OFF_PLPF3: prdata_o <= {16'h0, plpf_reg[2]};
        BRS_OFF_BATH:  prdata_o <= {16'h0, high_th_reg};
        BRS_OFF_BATL:  prdata_o <= {16'h0, low_th_reg};
        BRS_OFF_BLPF:  prdata_o <= {16'h0, blpf_reg};
        BRS_OFF_STAT:  prdata_o <= {29'h0, open_reg, auto_sel_reg};
        default:       prdata_o <= 32'h0;
      endcase
    end
  end

  // checks
  property p_hi_rail;
    @(posedge mclk_i) disable iff (!resetn_i)
      upd_tick && filt_reg[0] > high_th_reg |=> auto_sel_reg[0];
  endproperty
  a_hi_rail: assert property (p_hi_rail) else $error("no switch to high rail");

  property p_lo_rail;
    @(posedge mclk_i) disable iff (!resetn_i)
      upd_tick && filt_reg[0] < low_th_reg && filt_reg[0] <= high_th_reg |=> !auto_sel_reg[0];
  endproperty
  a_lo_rail: assert property (p_lo_rail) else $error("no switch to low rail");

  property p_hold;
    @(posedge mclk_i) disable iff (!resetn_i)
      !upd_tick |=> $stable(auto_sel_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("rail changed off tick");

  property p_band;
    @(posedge mclk_i) disable iff (!resetn_i)
      upd_tick && filt_reg[1] >= low_th_reg && filt_reg[1] <= high_th_reg |=> $stable(auto_sel_reg[1]);
  endproperty
  a_band: assert property (p_band) else $error("hysteresis band not held");

  property p_pin_auto;
    @(posedge mclk_i) disable iff (!resetn_i)
      relay_battery_control_reg[BRS_RLY_AUTO] |=> battery_rail_select_ch_a_o == $past(auto_sel_reg[0]);
  endproperty
  a_pin_auto: assert property (p_pin_auto) else $error("pin ignores auto choice");

  property p_pin_man;
    @(posedge mclk_i) disable iff (!resetn_i)
      !relay_battery_control_reg[BRS_RLY_AUTO]
        |=> battery_rail_select_ch_b_o == $past(relay_battery_control_reg[BRS_RLY_MAN]);
  endproperty
  a_pin_man: assert property (p_pin_man) else $error("pin ignores manual choice");

  property p_sticky;
    @(posedge mclk_i) disable iff (!resetn_i)
      cmp_now[0] && !cmp_prev_reg[0] |=> pend_reg[0] ##1 (pend_reg[0] || $past(wr_en));
  endproperty
  a_sticky: assert property (p_sticky) else $error("pending not set");

  property p_open;
    @(posedge mclk_i) disable iff (!resetn_i)
      |cmp_now |=> force_open_o;
  endproperty
  a_open: assert property (p_open) else $error("open state not forced");

  property p_ring;
    @(posedge mclk_i) disable iff (!resetn_i)
      !relay_battery_control_reg[BRS_RLY_THIRD_RAIL_PRESENT] |=> !ringing_rail_switch_out_o;
  endproperty
  a_ring: assert property (p_ring) else $error("ring switch without third rail");

  // a unity coefficient must hand the sampled level straight to the chooser
  property p_unity;
    @(posedge mclk_i) disable iff (!resetn_i)
      upd_tick && blpf_reg == BRS_UNITY |=> filt_reg[0] == $past(meas_i.vtr_a);
  endproperty
  a_unity: assert property (p_unity) else $error("unity filter does not pass level");

  // in discrete mode one pair's alarm raises both of its transistor flags
  property p_pair_bits;
    @(posedge mclk_i) disable iff (!resetn_i)
      relay_battery_control_reg[BRS_RLY_DISC] && cmp_now[2] && !cmp_prev_reg[2] |=> pend_reg[3:2] == 2'b11;
  endproperty
  a_pair_bits: assert property (p_pair_bits) else $error("pair alarm flags split");

  c_hi: cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(auto_sel_reg[0]));
  c_lo: cover property (@(posedge mclk_i) disable iff (!resetn_i) $fell(auto_sel_reg[0]));
  c_alarm: cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(pend_reg[0]));
  c_open: cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(force_open_o));
  c_lo_b: cover property (@(posedge mclk_i) disable iff (!resetn_i) $fell(battery_rail_select_ch_b_o));
endmodule : brs_top
`default_nettype wire

// file: inc/brs_pkg.sv
// Purpose: shared constants and types for the battery rail select and power alarm block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses; relay control sits at index 5
`default_nettype none
package brs_pkg;
  // register byte offsets
  localparam int         BRS_IDX_RELAY    = 5;      // relay control is register 5, one word each
  localparam logic [7:0] BRS_OFF_RELAY    = 8'(BRS_IDX_RELAY * 4);
  localparam logic [7:0] BRS_OFF_TOTAL_POWER_SUM     = 8'h00;
  localparam logic [7:0] BRS_OFF_PEND     = 8'h04;
  localparam logic [7:0] BRS_OFF_EN       = 8'h08;
  localparam logic [7:0] BRS_OFF_PTH1     = 8'h0c;
  localparam logic [7:0] BRS_OFF_PTH2     = 8'h10;
  localparam logic [7:0] BRS_OFF_PTH3     = 8'h18;
  localparam logic [7:0] BRS_OFF_PLPF1    = 8'h1c;
  localparam logic [7:0] BRS_OFF_PLPF2    = 8'h20;
  localparam logic [7:0] BRS_OFF_PLPF3    = 8'h24;
  localparam logic [7:0] BRS_OFF_BATH     = 8'h28;
  localparam logic [7:0] BRS_OFF_BATL     = 8'h2c;
  localparam logic [7:0] BRS_OFF_BLPF     = 8'h30;
  localparam logic [7:0] BRS_OFF_STAT     = 8'h34;
  // relay control fields
  localparam int BRS_RLY_AUTO  = 0;  // automatic battery selection enable
  localparam int BRS_RLY_THIRD_RAIL_PRESENT = 1;  // third rail present
  localparam int BRS_RLY_MANB  = 4;  // unused; channel b follows BRS_RLY_MAN like channel a
  localparam int BRS_RLY_MAN   = 5;  // manual rail choice
  localparam int BRS_RLY_DISC  = 6;  // 1: discrete transistors, 0: integrated linefeed
  // field positions
  localparam int BRS_TH_HI = 14;
  localparam int BRS_TH_LO = 7;
  localparam int BRS_CO_HI = 15;
  localparam int BRS_CO_LO = 3;
  // reset values
  localparam logic [7:0]  BRS_RLY_RST  = 8'h01;
  localparam logic [15:0] BRS_BLPF_RST = 16'h0a10;
  localparam logic [15:0] BRS_PTH_RST  = 16'hffff;  // alarms stay quiet until software lowers them
  localparam logic [15:0] BRS_UNITY    = 16'h4000;
  localparam logic [15:0] BRS_ZERO16   = 16'h0000;
  localparam logic [7:0]  BRS_ZERO8    = 8'h00;
  // timing: 800 Hz update from 125 MHz
  localparam longint BRS_CLK_HZ    = 125000000;
  localparam longint BRS_UPDATE_HZ = 800;
  localparam int     BRS_UPD_CYC   = int'(BRS_CLK_HZ / BRS_UPDATE_HZ);
  // per-channel measurement pair
  typedef struct packed {
    logic [15:0] vtr_a;
    logic [15:0] vtr_b;
  } brs_meas_t;
endpackage : brs_pkg
`default_nettype wire

// file: verification/brs_line_model.sv
// Purpose: linefeed stand-in giving tip-ring, power and cadence levels
// Assumes: the bench sets wanted levels right after a clock edge
// Notes:   all pairs see one power level, so the thresholds pick the pair
`default_nettype none
module brs_line_model (
  // wanted line conditions
  input  wire logic [15:0]        va_i,
  input  wire logic [15:0]        vb_i,
  input  wire logic [15:0]        total_power_sum_i,
  input  wire logic [15:0]        pair_i,
  input  wire logic               ring_i,
  // levels seen by the block
  output var  brs_pkg::brs_meas_t meas_o,
  output logic      [15:0]        total_power_o,
  output logic      [15:0]        pair_power_o [3],
  output logic                    cadence_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import brs_pkg::*;
  // pass-through keeps every level defined from time zero
  assign meas_o = '{vtr_a: va_i, vtr_b: vb_i};
  assign total_power_o = total_power_sum_i;
  assign pair_power_o = '{pair_i, pair_i, pair_i};
  assign cadence_o = ring_i;
endmodule : brs_line_model
`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench for rail selection and power alarms
// Assumes: zero wait apb slave, one update tick every UPD cycles
// Notes:   pin changes and read data are checked against queued notes
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import brs_pkg::*;
  localparam int UPD = 8;        // short tick keeps the run brief
  localparam int WT  = 5 * UPD;  // two ticks of pipeline plus margin
  logic        mclk_i;
  logic        resetn_i;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [15:0] va;
  logic [15:0] vb;
  logic [15:0] tp;
  logic [15:0] pp;
  logic        cad;
  logic [31:0] prdata;
  logic        pready;
  logic        sel_a;
  logic        sel_b;
  logic        ring;
  logic        fopen;
  brs_meas_t   meas;
  logic [15:0] tpow;
  logic [15:0] ppow [3];
  logic        cado;
  logic [31:0] rq [$];
  logic [3:0]  pq [$];
  logic [3:0]  last = 4'hx;
  logic [31:0] r;
  logic [31:0] exp_rd;
  logic [3:0]  exp_pin;
  int          seed = 32'h216d;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [7:0]  ra [9] = '{BRS_OFF_RELAY, BRS_OFF_BLPF, BRS_OFF_PLPF1, BRS_OFF_PTH1, BRS_OFF_PEND,
                          BRS_OFF_EN, BRS_OFF_BATH, BRS_OFF_BATL, 8'h3c};
  logic [31:0] rv [9] = '{32'h01, 32'h0a10, 32'h4000, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  // 125 MHz clock
  always #4 mclk_i = ~mclk_i;

  brs_line_model u_brs_line_model (
    .va_i(va), .vb_i(vb), .total_power_sum_i(tp), .pair_i(pp), .ring_i(cad),
    .meas_o(meas), .total_power_o(tpow), .pair_power_o(ppow), .cadence_o(cado)
  );
  brs_top #(.UPD_CYC(UPD)) u_brs_top (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(),
    .meas_i(meas), .total_power_i(tpow), .pair_power_i(ppow), .ringing_cadence_i(cado),
    .battery_rail_select_ch_a_o(sel_a), .battery_rail_select_ch_b_o(sel_b),
    .ringing_rail_switch_out_o(ring), .force_open_o(fopen)
  );

  // read data is taken at the edge that closes the access phase
  always @(posedge mclk_i)
  begin
    if (psel && pen && !pwr && pready === 1'b1)
    begin
      exp_rd = rq.size() ? rq.pop_front() : 32'hx;
      `CHK(prdata, exp_rd)
    end
  end

  // pins are looked at between edges, once all registers have settled
  always @(negedge mclk_i)
  begin
    if ({ring, fopen, sel_b, sel_a} !== last)
    begin
      last = {ring, fopen, sel_b, sel_a};
      exp_pin = pq.size() ? pq.pop_front() : 4'hx;
      `CHK(last, exp_pin)
    end
  end

  // one transfer; reads note the expected word first
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    if (!w)
      rq.push_back(d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge mclk_i);
    pen <= 1'b1;
    do
      @(posedge mclk_i);
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  end
  endtask : xfer

  // after n edges every noted pin change must have shown up
  task automatic step(input int n);
  begin
    repeat (n) @(posedge mclk_i);
    `CHK(pq.size(), 0)
  end
  endtask : step

  task automatic end_of_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask : end_of_test

  // main sequence
  initial
  begin
    mclk_i = 1'b0;
    resetn_i = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    va = 16'h7f00;
    vb = 16'h7f00;
    tp = 16'h0000;
    pp = 16'h0000;
    cad = 1'b0;
    pq.push_back(4'b0011);
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (ra[i])
      xfer(1'b0, ra[i], rv[i]);
    xfer(1'b1, BRS_OFF_BATH, 32'hffff);
    xfer(1'b0, BRS_OFF_BATH, 32'h7f80);
    xfer(1'b1, BRS_OFF_PLPF2, 32'hffff);
    xfer(1'b0, BRS_OFF_PLPF2, 32'hfff8);
    repeat (3)
    begin
      r = $random(seed);
      xfer(1'b1, BRS_OFF_PTH3, {16'h0, r[15:0]});
      xfer(1'b0, BRS_OFF_PTH3, {16'h0, r[15:0]});
    end
    xfer(1'b1, BRS_OFF_TOTAL_POWER_SUM, 32'h1234);
    xfer(1'b0, BRS_OFF_TOTAL_POWER_SUM, 32'h0);
    // automatic choice with hysteresis through a unity filter
    xfer(1'b1, BRS_OFF_BLPF, {16'h0, BRS_UNITY});
    xfer(1'b1, BRS_OFF_BATH, 32'h4000);
    xfer(1'b1, BRS_OFF_BATL, 32'h2000);
    pq.push_back(4'b0010);
    va <= 16'h1000;
    step(WT);
    va <= 16'h3000;
    step(WT);
    pq.push_back(4'b0011);
    va <= 16'h6000;
    step(WT);
    // channel b on its own: random level below low, then random level above high
    r = $random(seed);
    pq.push_back(4'b0001);
    vb <= {3'b000, r[12:0]};
    step(WT);
    pq.push_back(4'b0011);
    vb <= {2'b01, r[13:1], 1'b1};
    step(WT);
    // a zero coefficient freezes the filter, so the choice cannot move
    xfer(1'b1, BRS_OFF_BLPF, 32'h0);
    va <= 16'h1000;
    step(WT);
    pq.push_back(4'b0010);
    xfer(1'b1, BRS_OFF_BLPF, 32'h4000);
    step(WT);
    // manual choice needs automatic selection off first
    pq.push_back(4'b0011);
    xfer(1'b1, BRS_OFF_RELAY, 32'h20);
    step(WT);
    pq.push_back(4'b0000);
    xfer(1'b1, BRS_OFF_RELAY, 32'h00);
    step(WT);
    pq.push_back(4'b0010);
    xfer(1'b1, BRS_OFF_RELAY, 32'h01);
    step(WT);
    // ringing switch follows the cadence only with a third rail
    cad <= 1'b1;
    step(WT);
    cad <= 1'b0;
    xfer(1'b1, BRS_OFF_RELAY, 32'h03);
    pq.push_back(4'b1010);
    cad <= 1'b1;
    step(4);
    pq.push_back(4'b0010);
    cad <= 1'b0;
    step(4);
    // total power alarm is sticky and opens the line while masked
    xfer(1'b1, BRS_OFF_PTH1, 32'h0100);
    pq.push_back(4'b0110);
    tp <= 16'h0200;
    step(WT);
    xfer(1'b0, BRS_OFF_PEND, 32'h1);
    xfer(1'b0, BRS_OFF_TOTAL_POWER_SUM, 32'h0200);
    tp <= 16'h0000;
    step(WT);
    xfer(1'b0, BRS_OFF_PEND, 32'h1);
    xfer(1'b1, BRS_OFF_PEND, 32'h1);
    xfer(1'b0, BRS_OFF_PEND, 32'h0);
    pq.push_back(4'b0010);
    xfer(1'b1, BRS_OFF_RELAY, 32'h01);
    step(WT);
    xfer(1'b1, BRS_OFF_EN, 32'h3f);
    xfer(1'b0, BRS_OFF_EN, 32'h3f);
    // discrete transistors: one pair's alarm sets both of its bits
    xfer(1'b1, BRS_OFF_PTH1, 32'hffff);
    xfer(1'b1, BRS_OFF_PTH3, 32'hffff);
    xfer(1'b1, BRS_OFF_PTH2, 32'h0200);
    xfer(1'b1, BRS_OFF_RELAY, 32'h41);
    pq.push_back(4'b0110);
    pp <= 16'h0300;
    step(WT);
    xfer(1'b0, BRS_OFF_PEND, 32'h0c);
    end_of_test();
  end

  // the sequence needs under 3000 cycles; this cuts a hang short
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
